/* verilog/lsg_decoder.sv */
// LED select group decoder with pulse control and brightness checks
//
// Contract
// - Code 0000 disables driver, shunt enable high, colour selects low.
// - Low bits 00, upper nonzero: blanking current for colour in upper bits.
// - Low bits nonzero: driver enabled, upper bits group, low bits colour.
// - Four threshold sets held; set of current group is applied.
// - Big-capacitor switch high only during discontinuous operation.
// - Flag excessive brightness when secondary amplifier exceeds threshold.
// - Brightness comparison uses fast or filtered amplifier output, configurable.
// - Falling comparator edge reported per pulse in discontinuous mode; controller model counts them from reset on.
// - In discontinuous mode, shunt request falling edge gives on, off, on toggle of drive enable.
// - Per-colour time limit ends pulse via shunt enable if threshold missed.
`timescale 1ns/1ps
`default_nettype none

module lsg_decoder
  import lsg_pkg::*;
#(
  parameter int THR_WIDTH   = THR_W,
  parameter int LIMIT_WIDTH = LIMIT_W
)
(
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic                              clk_en,
  input  wire logic [SEL_W-1:0]                  led_select_code,
  input  wire logic                              shunt_request,
  input  wire logic                              photo_compare_raw,
  input  wire logic                              discontinuous_mode,
  input  wire logic [NUM_GROUPS-1:0][THR_WIDTH-1:0] group_threshold,
  input  wire logic [NUM_COLORS-1:0][LIMIT_WIDTH-1:0] pulse_limit,
  input  wire logic [THR_WIDTH-1:0]              secondary_transimpedance_amp_fast,
  input  wire logic [THR_WIDTH-1:0]              secondary_transimpedance_amp_filtered,
  input  wire logic                              bright_use_filtered,
  input  wire logic                              bright_check_enable,
  input  wire logic [THR_WIDTH-1:0]              bright_threshold,
  output logic                                   led_drive_enable,
  output logic                                   low_res_shunt_enable,
  output var lsg_colsel_t                        color_select,
  output logic [1:0]                             active_group,
  output logic [THR_WIDTH-1:0]                   photo_threshold,
  output logic                                   big_cap_switch,
  output logic                                   excess_brightness,
  output logic                                   photo_compare_out,
  output logic                                   compare_fall_pulse,
  output logic                                   pulse_timeout
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts when the second and third agree
  logic [2:0] sreq_sync_reg, sreq_sync_next;
  logic [2:0] cmp_sync_reg,  cmp_sync_next;
  logic       sreq_q_reg,    sreq_q_next;
  logic       cmp_q_reg,     cmp_q_next;

  always_comb
  begin
    sreq_sync_next = {sreq_sync_reg[1:0], shunt_request};
    cmp_sync_next  = {cmp_sync_reg[1:0], photo_compare_raw};
    sreq_q_next    = sreq_q_reg;
    cmp_q_next     = cmp_q_reg;
    if (sreq_sync_reg[1] == sreq_sync_reg[2])
    begin
      sreq_q_next = sreq_sync_reg[2];
    end
    if (cmp_sync_reg[1] == cmp_sync_reg[2])
    begin
      cmp_q_next = cmp_sync_reg[2];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sreq_sync_reg <= 3'h7;
      cmp_sync_reg  <= 3'h0;
      sreq_q_reg    <= 1'b1;
      cmp_q_reg     <= 1'b0;
    end
    else if (clk_en)
    begin
      sreq_sync_reg <= sreq_sync_next;
      cmp_sync_reg  <= cmp_sync_next;
      sreq_q_reg    <= sreq_q_next;
      cmp_q_reg     <= cmp_q_next;
    end
  end

  wire logic sreq_fall = sreq_q_reg & ~sreq_q_next;
  wire logic cmp_fall  = cmp_q_reg & ~cmp_q_next;

  // ----------------------------------------------------------------
  // Selection decode
  // ----------------------------------------------------------------
  function automatic lsg_rgb_t color_of(input logic [1:0] f);
    lsg_rgb_t c;
    c = '0;
    unique case (f)
      COL_RED:   c.red   = 1'b1;
      COL_GREEN: c.green = 1'b1;
      COL_BLUE:  c.blue  = 1'b1;
      FIELD_NONE: c = '0;
    endcase
    return c;
  endfunction : color_of

  wire logic [1:0] col_field = led_select_code[COLOR_LSB +: 2];
  wire logic [1:0] grp_field = led_select_code[GROUP_LSB +: 2];

  lsg_mode_t   mode_next;
  lsg_colsel_t colsel_next;

  always_comb
  begin
    mode_next   = LSG_OFF;
    colsel_next = '0;
    if (led_select_code == SEL_OFF)
    begin
      mode_next = LSG_OFF;
    end
    else if (col_field == FIELD_NONE)
    begin
      mode_next         = LSG_BLANK;
      colsel_next.blank = 1'b1;
      colsel_next.rgb   = color_of(grp_field);
    end
    else
    begin
      mode_next       = LSG_DRIVE;
      colsel_next.rgb = color_of(col_field);
    end
  end

  // ----------------------------------------------------------------
  // Pulse sequencing, drive and shunt
  // ----------------------------------------------------------------
  lsg_colsel_t      colsel_reg, colsel_reg_next;
  logic [1:0]       group_reg, group_next;
  logic [1:0]       col_reg, col_next;
  lsg_pulse_t       pstate_reg, pstate_next;
  logic [LIMIT_WIDTH-1:0] pcount_reg, pcount_next;
  logic             shunt_reg, shunt_next;
  logic             drive_reg, drive_next;
  logic             tmo_reg, tmo_next;
  logic             fall_reg, fall_next;
  logic [THR_WIDTH-1:0] thr_reg, thr_next;
  logic             bright_reg, bright_next;
  logic             cap_reg, cap_next;
  logic [THR_WIDTH-1:0] bright_src;

  always_comb
  begin
    colsel_reg_next = colsel_next;
    group_next      = (mode_next == LSG_DRIVE) ? grp_field : 2'h0;
    col_next        = (mode_next == LSG_DRIVE) ? col_field : 2'h0;
    pstate_next     = pstate_reg;
    pcount_next     = pcount_reg;
    shunt_next      = shunt_reg;
    drive_next      = drive_reg;
    tmo_next        = 1'b0;
    fall_next       = cmp_fall & discontinuous_mode;
    thr_next        = group_threshold[group_next];
    cap_next        = discontinuous_mode;
    bright_src      = bright_use_filtered ? secondary_transimpedance_amp_filtered : secondary_transimpedance_amp_fast;
    bright_next     = bright_check_enable & (bright_src > bright_threshold);

    if (mode_next != LSG_DRIVE)
    begin
      pstate_next = PS_IDLE;
      shunt_next  = 1'b1;
      drive_next  = 1'b0;
      pcount_next = LIMIT_ZERO;
    end
    else
    begin
      unique case (pstate_reg)
        PS_IDLE:
        begin
          drive_next = 1'b1;
          // Shunt follows the controller's request line while idle
          shunt_next = sreq_q_next;
          if (discontinuous_mode && sreq_fall)
          begin
            drive_next  = 1'b0;
            pstate_next = PS_OFF;
            pcount_next = LIMIT_ZERO;
          end
        end
        PS_OFF:
        begin
          // One-cycle off gap, then back on: the on-off-on toggle
          drive_next  = 1'b1;
          shunt_next  = 1'b0;
          pstate_next = PS_PULSE;
        end
        PS_PULSE:
        begin
          pcount_next = pcount_reg + LIMIT_ONE;
          if (sreq_q_next)
          begin
            shunt_next  = 1'b1;
            pstate_next = PS_IDLE;
          end
          else if (cmp_fall)
          begin
            shunt_next  = 1'b1;
            pstate_next = PS_HOLD;
          end
          else if (pcount_next >= pulse_limit[col_next - 2'h1])
          begin
            shunt_next  = 1'b1;
            tmo_next    = 1'b1;
            pstate_next = PS_HOLD;
          end
        end
        PS_HOLD:
        begin
          // Keep the shunt closed until the request line is seen high again;
          // following the still-low line here would restart LED current
          shunt_next = 1'b1;
          if (sreq_q_next)
          begin
            pstate_next = PS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      colsel_reg <= '0;
      group_reg  <= 2'h0;
      col_reg    <= 2'h0;
      pstate_reg <= PS_IDLE;
      pcount_reg <= LIMIT_ZERO;
      shunt_reg  <= 1'b1;
      drive_reg  <= 1'b0;
      tmo_reg    <= 1'b0;
      fall_reg   <= 1'b0;
      thr_reg    <= THR_RESET;
      bright_reg <= 1'b0;
      cap_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      colsel_reg <= colsel_reg_next;
      group_reg  <= group_next;
      col_reg    <= col_next;
      pstate_reg <= pstate_next;
      pcount_reg <= pcount_next;
      shunt_reg  <= shunt_next;
      drive_reg  <= drive_next;
      tmo_reg    <= tmo_next;
      fall_reg   <= fall_next;
      thr_reg    <= thr_next;
      bright_reg <= bright_next;
      cap_reg    <= cap_next;
    end
  end

  assign led_drive_enable     = drive_reg;
  assign low_res_shunt_enable = shunt_reg;
  assign color_select         = colsel_reg;
  assign active_group         = group_reg;
  assign photo_threshold      = thr_reg;
  assign big_cap_switch       = cap_reg;
  assign excess_brightness    = bright_reg;
  assign photo_compare_out    = cmp_q_reg;
  assign compare_fall_pulse   = fall_reg;
  assign pulse_timeout        = tmo_reg;

endmodule : lsg_decoder

`default_nettype wire

/* verilog/lsg_pkg.sv */
// Package of constants and types for the LED select group decoder
package lsg_pkg;

  // ----------------------------------------------------------------
  // Selection code layout
  // ----------------------------------------------------------------
  localparam int SEL_W      = 4;
  localparam int COLOR_LSB  = 0;
  localparam int GROUP_LSB  = 2;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_COLORS = 3;
  localparam int THR_W      = 12;
  localparam int LIMIT_W    = 16;

  localparam logic [3:0] SEL_OFF   = 4'h0;
  localparam logic [1:0] FIELD_NONE = 2'h0;
  localparam logic [1:0] COL_RED   = 2'h1;
  localparam logic [1:0] COL_GREEN = 2'h2;
  localparam logic [1:0] COL_BLUE  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LSG_OFF   = 2'b00,
    LSG_BLANK = 2'b01,
    LSG_DRIVE = 2'b10
  } lsg_mode_t;

  typedef struct packed
  {
    logic       red;
    logic       green;
    logic       blue;
  } lsg_rgb_t;

  typedef struct packed
  {
    logic       blank;
    lsg_rgb_t   rgb;
  } lsg_colsel_t;

  typedef enum logic [1:0]
  {
    PS_IDLE   = 2'b00,
    PS_OFF    = 2'b01,
    PS_PULSE  = 2'b10,
    PS_HOLD   = 2'b11
  } lsg_pulse_t;

  localparam logic [THR_W-1:0]   THR_RESET   = 12'h000;
  localparam logic [LIMIT_W-1:0] LIMIT_ZERO  = 16'h0000;
  localparam logic [LIMIT_W-1:0] LIMIT_ONE   = 16'h0001;

endpackage : lsg_pkg

/* tb/lsg_decoder_props.sv */
// Checker of the selection decoder port behaviour
`timescale 1ns/1ps
`default_nettype none
module lsg_decoder_props
  import lsg_pkg::*;
#(
  parameter int THR_WIDTH = THR_W
)
(
  input wire logic                                 clk_sys,
  input wire logic                                 reset,
  input wire logic                                 clk_en,
  input wire logic [SEL_W-1:0]                     led_select_code,
  input wire logic                                 discontinuous_mode,
  input wire logic [NUM_GROUPS-1:0][THR_WIDTH-1:0] group_threshold,
  input wire logic [THR_WIDTH-1:0]                 secondary_transimpedance_amp_fast,
  input wire logic [THR_WIDTH-1:0]                 secondary_transimpedance_amp_filtered,
  input wire logic                                 bright_use_filtered,
  input wire logic                                 bright_check_enable,
  input wire logic [THR_WIDTH-1:0]                 bright_threshold,
  input wire logic                                 led_drive_enable,
  input wire logic                                 low_res_shunt_enable,
  input wire lsg_colsel_t                          color_select,
  input wire logic [1:0]                           active_group,
  input wire logic [THR_WIDTH-1:0]                 photo_threshold,
  input wire logic                                 big_cap_switch,
  input wire logic                                 excess_brightness,
  input wire logic                                 photo_compare_out,
  input wire logic                                 compare_fall_pulse,
  input wire logic                                 pulse_timeout
);
  // Live is low on the cycle after reset or a frozen edge, where no new answer is due
  logic                 live;
  logic [THR_WIDTH-1:0] thr_exp;
  logic [1:0]           lo;
  logic [1:0]           hi;
  assign lo = led_select_code[1:0];
  assign hi = led_select_code[3:2];
  always_ff @(posedge clk_sys)
  begin
    live    <= clk_en && !reset;
    thr_exp <= group_threshold[hi];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || !clk_en);
  a_off_code: assert property (live && $past(led_select_code) == SEL_OFF |->
    !led_drive_enable && low_res_shunt_enable && color_select == 4'h0) else $error("off code decode wrong");
  a_blank_color: assert property (live && $past(lo) == 2'h0 && $past(hi) != 2'h0 |->
    !led_drive_enable && color_select == {1'b1, $past(hi) == COL_RED, $past(hi) == COL_GREEN, $past(hi) == COL_BLUE})
    else $error("blanking decode wrong");
  a_drive_group: assert property (live && $past(lo) != 2'h0 |-> active_group == $past(hi) &&
    color_select == {1'b0, $past(lo) == COL_RED, $past(lo) == COL_GREEN, $past(lo) == COL_BLUE})
    else $error("drive decode wrong");
  a_group_thr: assert property (live && $past(lo) != 2'h0 |-> photo_threshold == thr_exp)
    else $error("group threshold wrong");
  a_cap_follow: assert property (live |-> big_cap_switch == $past(discontinuous_mode))
    else $error("big cap switch wrong");
  a_bright_flag: assert property (live |-> excess_brightness == $past(bright_check_enable &&
    ((bright_use_filtered ? secondary_transimpedance_amp_filtered : secondary_transimpedance_amp_fast) > bright_threshold))) else $error("brightness flag wrong");
  a_fall_once: assert property (compare_fall_pulse |-> !photo_compare_out ##1 !compare_fall_pulse)
    else $error("fall pulse wrong");
  a_drive_toggle: assert property ($fell(led_drive_enable) && color_select.rgb != 3'h0 &&
    !color_select.blank && $stable(led_select_code) |=> led_drive_enable) else $error("drive toggle off too long");
  a_timeout_shunt: assert property (pulse_timeout |=> !pulse_timeout && low_res_shunt_enable)
    else $error("timeout did not shunt");
  c_fall: cover property (compare_fall_pulse);
  c_timeout: cover property (pulse_timeout);
  c_bright: cover property (excess_brightness);
endmodule : lsg_decoder_props
bind lsg_decoder lsg_decoder_props #(.THR_WIDTH(THR_WIDTH)) props_u (.*);
`default_nettype wire

/* tb/lsg_ctrl_model.sv */
// Display controller sequencer model driving the shunt request and comparator pins
`timescale 1ns/1ps
`default_nettype none
module lsg_ctrl_model
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic go,
  input  wire logic fire,
  input  wire logic compare_fall_pulse,
  input  wire logic pulse_timeout,
  output logic      shunt_request,
  output logic      photo_compare_raw,
  output logic      busy,
  output int        edge_count
);
  int t;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      shunt_request     <= 1'b1;
      photo_compare_raw <= 1'b0;
      busy              <= 1'b0;
      edge_count        <= 0;
      t                 <= 0;
    end
    else
    begin
      if (compare_fall_pulse)
        edge_count <= edge_count + 1;
      if (go && !busy)
      begin
        // A new pulse is only asked for from shunt high
        busy              <= 1'b1;
        shunt_request     <= 1'b0;
        photo_compare_raw <= fire;
        t                 <= 0;
      end
      else if (busy)
      begin
        t <= t + 1;
        if (t == 8)
          photo_compare_raw <= 1'b0;
        if (compare_fall_pulse || pulse_timeout)
        begin
          shunt_request <= 1'b1;
          busy          <= 1'b0;
        end
      end
    end
  end
endmodule : lsg_ctrl_model
`default_nettype wire

/* tb/lsg_decoder_tb.sv */
// Testbench of the LED select group decoder
`timescale 1ns/1ps
`default_nettype none
module lsg_decoder_tb;
  import lsg_pkg::*;
  logic clk_sys = 0, reset = 1, disc = 0, use_f = 0, bchk = 0, go = 0, fire = 0, en = 1;
  logic [SEL_W-1:0] code = SEL_OFF;
  logic [NUM_GROUPS-1:0][THR_W-1:0] gthr = {12'h444, 12'h333, 12'h222, 12'h111};
  logic [NUM_COLORS-1:0][LIMIT_W-1:0] plim = {3{16'h0014}};
  logic [THR_W-1:0] tf = 12'h000, tl = 12'h000, bthr = 12'h100, pthr;
  logic drv, shunt, cap, xb, pco, cfp, pto, sreq, raw, busy;
  lsg_colsel_t colsel;
  logic [1:0] grp;
  int edges, tos = 0, fails = 0, tests_run = 0, cyc = 0;
  initial forever #5 clk_sys = ~clk_sys;
  lsg_decoder dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(en), .led_select_code(code), .shunt_request(sreq),
    .photo_compare_raw(raw), .discontinuous_mode(disc), .group_threshold(gthr), .pulse_limit(plim), .secondary_transimpedance_amp_fast(tf),
    .secondary_transimpedance_amp_filtered(tl), .bright_use_filtered(use_f), .bright_check_enable(bchk), .bright_threshold(bthr),
    .led_drive_enable(drv), .low_res_shunt_enable(shunt), .color_select(colsel), .active_group(grp),
    .photo_threshold(pthr), .big_cap_switch(cap), .excess_brightness(xb), .photo_compare_out(pco),
    .compare_fall_pulse(cfp), .pulse_timeout(pto));
  lsg_ctrl_model ctrl_u (.clk_sys(clk_sys), .reset(reset), .go(go), .fire(fire), .compare_fall_pulse(cfp),
    .pulse_timeout(pto), .shunt_request(sreq), .photo_compare_raw(raw), .busy(busy), .edge_count(edges));
  always @(posedge clk_sys)
  begin
    cyc++;
    if (pto === 1'b1) tos++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task bcase(input logic f, input logic [11:0] fa, input logic [11:0] fl, input logic [11:0] th, input logic e);
    @(posedge clk_sys);
    use_f <= f;
    tf <= fa;
    tl <= fl;
    bthr <= th;
    tick(2);
    chk(16'(xb), 16'(e));
  endtask : bcase
  task pulse(input logic f);
    @(posedge clk_sys);
    go <= 1'b1;
    fire <= f;
    @(posedge clk_sys);
    go <= 1'b0;
    tick(4);
    chk(16'(drv), 16'h0000);
    tick(1);
    chk(16'(drv), 16'h0001);
    tick(2);
    chk(16'(shunt), 16'h0000);
    chk(16'(pco), 16'(f));
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
    tick(2);
    chk(16'(shunt), 16'h0001);
  endtask : pulse
  initial
  begin
    logic [1:0] lo, hi;
    tick(3);
    reset <= 1'b0;
    tick(5);
    chk({drv, shunt, 4'(colsel)}, 6'h10);
    @(posedge clk_sys);
    en <= 1'b0;
    code <= 4'h9;
    tick(3);
    chk({drv, shunt, 4'(colsel), grp}, 8'h40);
    en <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      lo = 2'(i);
      hi = 2'(i >> 2);
      @(posedge clk_sys);
      code <= 4'(i);
      tick(2);
      if (lo == 2'h0) chk({drv, shunt, 4'(colsel), grp}, {2'b01, hi != 0, hi == 1, hi == 2, hi == 3, 2'h0});
      else chk({drv, shunt, 4'(colsel), grp}, {3'b110, lo == 1, lo == 2, lo == 3, hi});
      if (lo != 2'h0) chk(16'(pthr), 16'(gthr[hi]));
    end
    bchk <= 1'b1;
    bcase(1'b0, 12'h101, 12'h000, 12'h100, 1'b1);
    bcase(1'b0, 12'h100, 12'hfff, 12'h100, 1'b0);
    bcase(1'b1, 12'hfff, 12'h100, 12'h100, 1'b0);
    bcase(1'b1, 12'h000, 12'h101, 12'h100, 1'b1);
    bcase(1'b1, 12'h000, 12'h100, 12'h0ff, 1'b1);
    bchk <= 1'b0;
    bcase(1'b1, 12'h000, 12'h101, 12'h100, 1'b0);
    disc <= 1'b1;
    @(posedge clk_sys);
    code <= 4'h5;
    tick(3);
    chk(16'(cap), 16'h0001);
    pulse(1'b1);
    chk(16'(edges), 16'h0001);
    gthr[1] <= 12'h123;
    tick(2);
    chk(16'(pthr), 16'h0123);
    pulse(1'b0);
    chk(16'(tos), 16'h0001);
    chk(16'(edges), 16'h0001);
    disc <= 1'b0;
    @(posedge clk_sys);
    code <= SEL_OFF;
    tick(3);
    chk({cap, drv, shunt, 4'(colsel)}, 7'h10);
    tally_and_finish();
  end
endmodule : lsg_decoder_tb
`default_nettype wire
